// ===== include/tmref_regs.vh
/*
  Register map, field positions, reset values and slave mode codes
  of the timer event-flag block.
  Assumes a 32-bit APB data bus and byte addresses on paddr.
*/
`ifndef TMREF_REGS_VH
`define TMREF_REGS_VH

// register byte offsets
`define TMREF_OFF_SLAVE_MODE      8'h08
`define TMREF_OFF_REQUEST_ENABLE  8'h0C
`define TMREF_OFF_EVENT_FLAGS     8'h10

// reset values
`define TMREF_RST_SLAVE_MODE      3'h0
`define TMREF_RST_REQUEST_ENABLE  15'h0000
`define TMREF_RST_EVENT_FLAGS     13'h0000

// slave mode field
`define TMREF_SMS_LSB             0
`define TMREF_SMS_MSB             2
`define TMREF_MODE_RESTART        3'h4
`define TMREF_MODE_PAUSE          3'h5
`define TMREF_MODE_EVENT          3'h6
`define TMREF_MODE_EXTCLK0        3'h7

// request enable register fields
`define TMREF_EN_UPDATE_IRQ       0
`define TMREF_EN_CHAN_IRQ_LSB     1
`define TMREF_EN_CHAN_IRQ_MSB     4
`define TMREF_EN_COMMUT_IRQ       5
`define TMREF_EN_TRIG_IRQ         6
`define TMREF_EN_BREAK_IRQ        7
`define TMREF_EN_UPDATE_DMA       8
`define TMREF_EN_CHAN_DMA_LSB     9
`define TMREF_EN_CHAN_DMA_MSB     12
`define TMREF_EN_COMMUT_DMA       13
`define TMREF_EN_TRIG_DMA         14
`define TMREF_EN_WIDTH            15

// event flag register fields
`define TMREF_FL_UPDATE           0
`define TMREF_FL_CHAN_LSB         1
`define TMREF_FL_CHAN_MSB         4
`define TMREF_FL_COMMUT           5
`define TMREF_FL_TRIG             6
`define TMREF_FL_BREAK            7
`define TMREF_FL_OVER_LSB         9
`define TMREF_FL_OVER_MSB         12
`define TMREF_FL_WIDTH            13
`define TMREF_FL_IMPL_MASK        13'h1EFF

`endif

// ===== rtl/tmref_slave_mode.v
/*
  Trigger edge detection and the restart, pause, event and external
  clock 0 slave modes.
  Assumes i_trig is the selected, filtered trigger on i_clock.
*/
`timescale 1ns/100ps
`include "tmref_regs.vh"

module tmref_slave_mode (
  input  wire       i_clock,
  input  wire       i_nrst,
  input  wire [2:0] i_mode,
  input  wire       i_trig,
  output reg        o_trig_event,
  output reg        o_reinit,
  output reg        o_count_gate,
  output reg        o_start_count,
  output reg        o_ext_tick
);

  reg  trig_q;
  wire trig_rise;
  wire trig_fall;

  assign trig_rise = i_trig & ~trig_q;
  assign trig_fall = ~i_trig & trig_q;

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      trig_q        <= 1'b0;
      o_trig_event  <= 1'b0;
      o_reinit      <= 1'b0;
      o_count_gate  <= 1'b1;
      o_start_count <= 1'b0;
      o_ext_tick    <= 1'b0;
    end else begin
      trig_q <= i_trig;
      // pause mode reports both edges as trigger events
      if (i_mode == `TMREF_MODE_PAUSE) begin
        o_trig_event <= trig_rise | trig_fall;
        o_count_gate <= i_trig;
      end else begin
        o_trig_event <= trig_rise;
        o_count_gate <= 1'b1;
      end
      o_reinit      <= trig_rise & (i_mode == `TMREF_MODE_RESTART);
      o_start_count <= trig_rise & (i_mode == `TMREF_MODE_EVENT);
      o_ext_tick    <= trig_rise & (i_mode == `TMREF_MODE_EXTCLK0);
    end
  end

endmodule // tmref_slave_mode

// ===== rtl/tmref_top.v
/*
  Event flags, interrupt and DMA request enables of a timer, with the
  slave mode register, behind an APB slave.
  Assumes all event inputs are one-cycle pulses from the counter core
  on i_clock; the break level and the trigger arrive as levels from
  outside the clock domain and are synchronised here.
*/
// Decided for this implementation: register access over APB.
// Operation
// - restart mode: trigger rise reinitialises, updates
// - pause mode: trigger level gates counter clock
// - event mode: trigger rise starts counter
// - external clock 0: count on trigger rises
// - DMA enables at bits 14 to 8
// - interrupt enables at bits 7 to 0
// - capture while flag set sets over-capture
// - break flag; clear only when break inactive
// - trigger flag; both edges in pause mode
// - commutation flag sticky until software clears
// - channel flag on capture or compare
// - captured value read clears input channel flag
// - update flag sticky until software clears
// - enables 0x0C, flags 0x10, reset zero
`timescale 1ns/100ps
`include "tmref_regs.vh"

module tmref_top (
  input  wire        i_clock,
  input  wire        i_nrst,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output wire        o_pslverr,
  output reg  [31:0] o_prdata,
  // events from the counter core
  input  wire        i_update_evt,
  input  wire [3:0]  i_cc_evt,
  input  wire [3:0]  i_chan_input_mode,
  input  wire [3:0]  i_capture_read,
  input  wire        i_commutation_evt,
  // asynchronous levels
  input  wire        i_break_active,
  input  wire        i_trig,
  // to the counter core
  output wire        o_counter_reinit,
  output wire        o_count_gate,
  output wire        o_start_count,
  output wire        o_ext_tick,
  // requests
  output reg         o_irq,
  output reg         o_dma_update,
  output reg  [3:0]  o_dma_chan,
  output reg         o_dma_commutation,
  output reg         o_dma_trig
);

  reg  [2:0]                 slave_mode;
  reg  [`TMREF_EN_WIDTH-1:0] request_enable;
  reg  [`TMREF_FL_WIDTH-1:0] event_flags;
  reg  [`TMREF_FL_WIDTH-1:0] next_flags;
  reg  [`TMREF_FL_WIDTH-1:0] set_vec;
  reg  [31:0]                next_prdata;
  reg                        brk_meta;
  reg                        brk_sync;
  reg                        trig_meta;
  reg                        trig_sync;
  wire                       setup_phase;
  wire                       wr_access;
  wire                       trig_event;
  wire                       restart_update;
  wire                       update_all;
  wire [3:0]                 capture_evt;
  wire [3:0]                 over_evt;
  wire [3:0]                 cc_clear;

  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr[7:2] == off[7:2]);
    end
  endfunction

  // two-flop synchronisers; only the second stage is read
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      brk_meta  <= 1'b0;
      brk_sync  <= 1'b0;
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
    end else begin
      brk_meta  <= i_break_active;
      brk_sync  <= brk_meta;
      trig_meta <= i_trig;
      trig_sync <= trig_meta;
    end
  end

  tmref_slave_mode u_slave_mode (
    .i_clock       (i_clock),
    .i_nrst        (i_nrst),
    .i_mode        (slave_mode),
    .i_trig        (trig_sync),
    .o_trig_event  (trig_event),
    .o_reinit      (restart_update),
    .o_count_gate  (o_count_gate),
    .o_start_count (o_start_count),
    .o_ext_tick    (o_ext_tick)
  );

  assign o_counter_reinit = restart_update;
  assign update_all       = i_update_evt | restart_update;

  // zero-wait slave; unmapped reads give zero, writes are dropped
  assign o_pready    = 1'b1;
  assign o_pslverr   = 1'b0;
  assign setup_phase = i_psel & ~i_penable;
  assign wr_access   = i_psel & i_penable & i_pwrite;

  // read data is latched in setup so it comes from a flop
  always @* begin
    next_prdata = 32'h00000000;
    if (hit(i_paddr, `TMREF_OFF_SLAVE_MODE)) begin
      next_prdata[`TMREF_SMS_MSB:`TMREF_SMS_LSB] = slave_mode;
    end else if (hit(i_paddr, `TMREF_OFF_REQUEST_ENABLE)) begin
      next_prdata[`TMREF_EN_WIDTH-1:0] = request_enable;
    end else if (hit(i_paddr, `TMREF_OFF_EVENT_FLAGS)) begin
      next_prdata[`TMREF_FL_WIDTH-1:0] = event_flags;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h00000000;
    end else if (setup_phase && !i_pwrite) begin
      o_prdata <= next_prdata;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      slave_mode     <= `TMREF_RST_SLAVE_MODE;
      request_enable <= `TMREF_RST_REQUEST_ENABLE;
    end else if (wr_access) begin
      if (hit(i_paddr, `TMREF_OFF_SLAVE_MODE)) begin
        slave_mode <= i_pwdata[`TMREF_SMS_MSB:`TMREF_SMS_LSB];
      end
      // bits 31:15 are not stored, so stray ones read back as zero
      if (hit(i_paddr, `TMREF_OFF_REQUEST_ENABLE)) begin
        request_enable <= i_pwdata[`TMREF_EN_WIDTH-1:0];
      end
    end
  end

  // captures only count for channels in input mode
  assign capture_evt = i_cc_evt & i_chan_input_mode;
  assign over_evt    = capture_evt &
                       event_flags[`TMREF_FL_CHAN_MSB:`TMREF_FL_CHAN_LSB];
  assign cc_clear    = i_capture_read & i_chan_input_mode;

  always @* begin
    set_vec = {`TMREF_FL_WIDTH{1'b0}};
    set_vec[`TMREF_FL_UPDATE] = update_all;
    set_vec[`TMREF_FL_CHAN_MSB:`TMREF_FL_CHAN_LSB] = i_cc_evt;
    set_vec[`TMREF_FL_COMMUT] = i_commutation_evt;
    set_vec[`TMREF_FL_TRIG] = trig_event;
    set_vec[`TMREF_FL_BREAK] = brk_sync;
    set_vec[`TMREF_FL_OVER_MSB:`TMREF_FL_OVER_LSB] = over_evt;
  end

  always @* begin
    next_flags = event_flags;
    if (wr_access && hit(i_paddr, `TMREF_OFF_EVENT_FLAGS)) begin
      // a zero clears, a one keeps the flag
      next_flags = event_flags & i_pwdata[`TMREF_FL_WIDTH-1:0];
      if (brk_sync) begin
        next_flags[`TMREF_FL_BREAK] = event_flags[`TMREF_FL_BREAK];
      end
    end
    next_flags[`TMREF_FL_CHAN_MSB:`TMREF_FL_CHAN_LSB] =
      next_flags[`TMREF_FL_CHAN_MSB:`TMREF_FL_CHAN_LSB] & ~cc_clear;
    // hardware set applied last so it beats any clear
    next_flags = (next_flags | set_vec) & `TMREF_FL_IMPL_MASK;
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      event_flags <= `TMREF_RST_EVENT_FLAGS;
    end else begin
      event_flags <= next_flags;
    end
  end

  // interrupt is a level; over-capture has no enable of its own
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq             <= 1'b0;
      o_dma_update      <= 1'b0;
      o_dma_chan        <= 4'h0;
      o_dma_commutation <= 1'b0;
      o_dma_trig        <= 1'b0;
    end else begin
      o_irq <= |(next_flags[`TMREF_EN_BREAK_IRQ:0] &
                 request_enable[`TMREF_EN_BREAK_IRQ:0]);
      o_dma_update <= update_all &
                      request_enable[`TMREF_EN_UPDATE_DMA];
      o_dma_chan <= i_cc_evt &
        request_enable[`TMREF_EN_CHAN_DMA_MSB:`TMREF_EN_CHAN_DMA_LSB];
      o_dma_commutation <= i_commutation_evt &
                           request_enable[`TMREF_EN_COMMUT_DMA];
      o_dma_trig <= trig_event &
                    request_enable[`TMREF_EN_TRIG_DMA];
    end
  end

endmodule // tmref_top

// ===== tb/timer_event_flags_and_requests_test.sv
/*
  Bench for tmref_top: APB register accesses, event pulses, break and
  trigger levels, with expected flags and request counts.
  Assumes tmref_regs.vh on the include path.
*/
`timescale 1ns/100ps

module timer_event_flags_and_requests_test;
  logic        i_clock, i_nrst, i_psel, i_penable, i_pwrite, i_trig;
  logic        i_update_evt, i_commutation_evt, i_break_active;
  logic [7:0]  i_paddr, exp_cnt [10], cnt [10];
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [3:0]  i_cc_evt, i_chan_input_mode, i_capture_read, o_dma_chan;
  logic        o_pready, o_pslverr, o_counter_reinit, o_count_gate;
  logic        o_start_count, o_ext_tick, o_irq, o_dma_update;
  logic        o_dma_commutation, o_dma_trig;
  int          num_errors, num_checks, cyc;

  tmref_top tmref_top_inst (.*);
  tmref_far_model tmref_far_model_inst (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_req({o_ext_tick, o_start_count, o_counter_reinit, o_dma_trig,
            o_dma_commutation, o_dma_chan, o_dma_update}), .o_cnt(cnt));

  always #2 i_clock = ~i_clock;

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge i_clock) if (++cyc == 3000) begin
    num_errors++;
    summarize();
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
    @(posedge i_clock);
    i_penable <= 1'b1;
    @(posedge i_clock);
    while (o_pready !== 1'b1) @(posedge i_clock);
    rd = o_prdata;
    {i_psel, i_penable} <= 2'b00;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd, e);
  endtask

  task automatic ev(input logic u, input logic [3:0] cc, rdc, input logic c);
    @(posedge i_clock);
    {i_update_evt, i_cc_evt, i_capture_read, i_commutation_evt} <= {u, cc, rdc, c};
    @(posedge i_clock);
    {i_update_evt, i_cc_evt, i_capture_read, i_commutation_evt} <= 10'h000;
  endtask

  task automatic bump(input logic [9:0] m);
    for (int k = 0; k < 10; k++) if (m[k]) exp_cnt[k]++;
  endtask

  task automatic chk_cnt();
    repeat (3) @(posedge i_clock);
    for (int k = 0; k < 10; k++)
      check($sformatf("count %0d", k), {24'h0, cnt[k]}, {24'h0, exp_cnt[k]});
  endtask

  initial begin
    {i_clock, i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    {i_update_evt, i_cc_evt, i_chan_input_mode, i_capture_read} = '0;
    {i_commutation_evt, i_break_active, i_trig} = '0;
    {num_errors, num_checks, cyc} = '0;
    foreach (exp_cnt[k]) exp_cnt[k] = 8'h00;
    repeat (3) @(posedge i_clock);
    i_nrst <= 1'b1;
    rchk(8'h0C, 32'h0);
    rchk(8'h10, 32'h0);
    apb(1'b1, 8'h0C, 32'h7FFF);
    rchk(8'h0C, 32'h7FFF);
    rchk(8'h04, 32'h0);
    apb(1'b1, 8'h20, 32'h0);
    rchk(8'h0C, 32'h7FFF);
    // second capture on channel 0 while its flag is still up
    i_chan_input_mode <= 4'hF;
    ev(1'b1, 4'h1, 4'h0, 1'b1);
    ev(1'b0, 4'hF, 4'h0, 1'b0);
    bump(10'h023);
    bump(10'h01E);
    chk_cnt();
    rchk(8'h10, 32'h23F);
    check("irq", o_irq, 1'b1);
    ev(1'b0, 4'h0, 4'h1, 1'b0);
    rchk(8'h10, 32'h23D);
    apb(1'b1, 8'h10, 32'h1EFE);
    rchk(8'h10, 32'h23C);
    apb(1'b1, 8'h10, 32'h0);
    rchk(8'h10, 32'h0);
    check("irq", o_irq, 1'b0);
    // output mode: compare sets the flag, no over-capture, read keeps it
    i_chan_input_mode <= 4'h0;
    // read comes after the compare, so only a missing clear keeps the flag
    ev(1'b0, 4'h4, 4'h0, 1'b0);
    ev(1'b0, 4'h0, 4'h4, 1'b0);
    bump(10'h008);
    chk_cnt();
    rchk(8'h10, 32'h8);
    apb(1'b1, 8'h10, 32'h0);
    i_break_active <= 1'b1;
    repeat (5) @(posedge i_clock);
    rchk(8'h10, 32'h80);
    apb(1'b1, 8'h10, 32'h0);
    rchk(8'h10, 32'h80);
    i_break_active <= 1'b0;
    repeat (5) @(posedge i_clock);
    apb(1'b1, 8'h10, 32'h0);
    rchk(8'h10, 32'h0);
    for (int m = 4; m < 8; m++) begin
      apb(1'b1, 8'h08, m);
      i_trig <= 1'b1;
      repeat (8) @(posedge i_clock);
      check("gate hi", o_count_gate, 1'b1);
      i_trig <= 1'b0;
      repeat (8) @(posedge i_clock);
      check("gate lo", o_count_gate, m != 5);
      bump(m == 4 ? 10'h0C1 : m == 5 ? 10'h040 : m == 6 ? 10'h140 : 10'h240);
      if (m == 5) bump(10'h040);
      chk_cnt();
      rchk(8'h10, m == 4 ? 32'h41 : 32'h40);
      apb(1'b1, 8'h10, 32'h0);
    end
    apb(1'b1, 8'h0C, 32'h0);
    ev(1'b1, 4'h0, 4'h0, 1'b0);
    chk_cnt();
    check("irq", o_irq, 1'b0);
    rchk(8'h10, 32'h1);
    summarize();
  end
endmodule // timer_event_flags_and_requests_test

// ===== tb/tmref_far_model.sv
/*
  Far side: DMA controller and counter core, counting each
  request pulse handed to it.
  Assumes one-cycle pulses sampled on the rising clock edge.
*/
`timescale 1ns/100ps

module tmref_far_model (
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic [9:0] i_req,
  output logic      [7:0] o_cnt [10]
);
  // counting, not edge-spotting: a held request would show as extra
  always @(posedge i_clock or negedge i_nrst)
    for (int k = 0; k < 10; k++)
      if (!i_nrst) o_cnt[k] <= 8'h00;
      else if (i_req[k]) o_cnt[k] <= o_cnt[k] + 8'h01;
endmodule // tmref_far_model

// ===== tb/tmref_props.sv
/*
  Port checker for tmref_top: APB answer, request pulses, trigger-driven
  slave mode outputs.
  Assumes bind to tmref_top; one clock domain, async active-low reset.
*/
`timescale 1ns/100ps

module tmref_props (
  input wire        i_clock,
  input wire        i_nrst,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire        i_update_evt,
  input wire [3:0]  i_cc_evt,
  input wire        i_commutation_evt,
  input wire        i_trig,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire [31:0] o_prdata,
  input wire        o_counter_reinit,
  input wire        o_count_gate,
  input wire        o_start_count,
  input wire        o_ext_tick,
  input wire        o_dma_update,
  input wire [3:0]  o_dma_chan,
  input wire        o_dma_commutation
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  // trigger seen rising through the 2-flop sync and edge register
  sequence s_trig_rose;
    $past(i_trig, 3) && !$past(i_trig, 4);
  endsequence

  property p_ready; o_pready && !o_pslverr; endproperty
  a_ready: assert property (p_ready) else $error("apb answer wrong");
  property p_rdata;
    !(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("prdata moved");
  property p_dma_upd;
    o_dma_update |-> $past(i_update_evt) || $past(o_counter_reinit);
  endproperty
  a_dma_upd: assert property (p_dma_upd) else $error("stray upd dma");
  property p_dma_chan;
    o_dma_chan != 4'h0 |-> (o_dma_chan & ~$past(i_cc_evt)) == 4'h0;
  endproperty
  a_dma_chan: assert property (p_dma_chan) else $error("stray ch dma");
  property p_dma_com; o_dma_commutation |-> $past(i_commutation_evt);
  endproperty
  a_dma_com: assert property (p_dma_com) else $error("stray com dma");
  property p_gate; !o_count_gate |-> !$past(i_trig, 3); endproperty
  a_gate: assert property (p_gate) else $error("gate low, trig high");
  property p_reinit; o_counter_reinit |-> s_trig_rose; endproperty
  a_reinit: assert property (p_reinit) else $error("reinit no edge");
  property p_start; o_start_count |-> s_trig_rose; endproperty
  a_start: assert property (p_start) else $error("start no edge");
  property p_tick; o_ext_tick |-> s_trig_rose; endproperty
  a_tick: assert property (p_tick) else $error("tick no edge");
  property p_excl;
    $onehot0({o_counter_reinit, o_start_count, o_ext_tick});
  endproperty
  a_excl: assert property (p_excl) else $error("modes overlap");
endmodule // tmref_props

bind tmref_top tmref_props tmref_props_inst (.*);
